// ---- logic/fpss_pkg.sv ----
package fpss_pkg;
   // ---------------------------------------------------------------
   // Command codes
   // ---------------------------------------------------------------
   localparam logic [7:0] CMD_PROG_SETUP = 8'h40;
   localparam logic [7:0] CMD_PROG_ALT = 8'h10;
   localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
   localparam logic [7:0] CMD_READ_STATUS = 8'h70;
   localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
   localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
   localparam logic [7:0] CMD_ERASE_CONFIRM = 8'hD0;
   localparam logic [7:0] CMD_SUSPEND = 8'hB0;
   localparam logic [7:0] CMD_RESUME = 8'hD0;
   // ---------------------------------------------------------------
   // Status bit positions
   // ---------------------------------------------------------------
   localparam int SR_READY = 7;
   localparam int SR_ERASE_SUSP = 6;
   localparam int SR_ERASE_ERR = 5;
   localparam int SR_PROG_ERR = 4;
   localparam int SR_VPP_LOW = 3;
   localparam int SR_PROG_SUSP = 2;
   localparam int SR_LOCK = 1;
   localparam logic [7:0] SR_RESET = 8'h80;
   // ---------------------------------------------------------------
   // Timing in cycles of the 100 MHz clock
   // ---------------------------------------------------------------
   localparam int CLK_MHZ = 100;
   localparam int PROG_TIME_US = 8;
   localparam int ERASE_TIME_US = 30;
   localparam int SUSP_LAT_NS = 50;
   localparam int PROG_CYC = PROG_TIME_US * CLK_MHZ;
   localparam int ERASE_CYC = ERASE_TIME_US * CLK_MHZ;
   localparam int SUSP_CYC = (SUSP_LAT_NS * CLK_MHZ + 999) / 1000;
   localparam int CNT_W = 16;
endpackage

// ---- logic/fpss_if.sv ----
`timescale 1ns/1ps
// Bus cycles between host and flash: one write or read per strobe
interface fpss_if #(parameter int AW = 16, parameter int DW = 16);
   logic ce_n;
   logic we;
   logic rd;
   logic [AW-1:0] addr;
   logic [DW-1:0] wdata;
   logic [DW-1:0] rdata;
   logic rvalid;
   modport dev (input ce_n, input we, input rd, input addr, input wdata,
      output rdata, output rvalid);
   modport host (output ce_n, output we, output rd, output addr, output wdata,
      input rdata, input rvalid);
endinterface

// ---- logic/fpss_device.sv ----
// Chosen here: the block size (BLK_SHIFT) and the plain strobed port.
`timescale 1ns/1ps
module fpss_device #(
   parameter int AW = 16,
   parameter int DW = 16,
   parameter int PROG_CYCLES = fpss_pkg::PROG_CYC,
   parameter int ERASE_CYCLES = fpss_pkg::ERASE_CYC,
   parameter int SUSP_CYCLES = fpss_pkg::SUSP_CYC,
   parameter int BLK_SHIFT = 12
) (
   // Clock and reset
   input wire logic CLK_IN,
   input wire logic RST_IN,
   // Bus from host
   fpss_if.dev BUS,
   // Array port, fault inputs, standby and busy outputs
   input wire logic [DW-1:0] ARRAY_DATA_IN,
   input wire logic PROG_FAIL_IN,
   input wire logic VPP_LOW_IN,
   input wire logic LOCKED_IN,
   output logic [AW-1:0] ARRAY_ADDR_OUT,
   output logic STANDBY_OUT,
   output logic BUSY_OUT
);
   // ---------------------------------------------------------------
   // State types
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_PSETUP = 3'b001,
      ST_PROG = 3'b010,
      ST_ESETUP = 3'b011,
      ST_ERASE = 3'b100
   } fpss_st_e;
   typedef enum logic [1:0] {
      EN_NONE = 2'b00,
      EN_RUN = 2'b01,
      EN_SUSPING = 2'b10,
      EN_SUSP = 2'b11
   } fpss_sub_e;

   localparam int CNT_W_L = fpss_pkg::CNT_W;
   fpss_st_e st_r;
   fpss_sub_e er_r, pg_r;
   logic [7:0] sr_r;
   logic rd_status_r;
   logic [CNT_W_L-1:0] pcnt_r, ecnt_r;
   logic [CNT_W_L-1:0] slat_r;
   logic [AW-1:0] paddr_r, eaddr_r;
   logic [DW-1:0] rdata_r;
   logic rvalid_r;

   // ---------------------------------------------------------------
   // Command decode
   // ---------------------------------------------------------------
   wire wr = BUS.we && !BUS.ce_n;
   wire [7:0] cmd = BUS.wdata[7:0];
   wire is_prog = (cmd == fpss_pkg::CMD_PROG_SETUP) || (cmd == fpss_pkg::CMD_PROG_ALT);
   wire e_susp = (er_r == EN_SUSP);
   wire p_susp = (pg_r == EN_SUSP);
   wire same_blk = (BUS.addr >> BLK_SHIFT) == (eaddr_r >> BLK_SHIFT);
   wire prog_run = (pg_r == EN_RUN);
   wire prog_done = prog_run && (pcnt_r == '0);
   wire erase_done = (er_r == EN_RUN) && (ecnt_r == '0) && (pg_r == EN_NONE);
   // Fault at program end and program suspend taking hold, so a set beats a clear
   wire fault_any = PROG_FAIL_IN | VPP_LOW_IN | LOCKED_IN;
   wire psusp_set = (pg_r == EN_SUSPING) && (slat_r == '0);
   // Accepted commands during suspends; others are improper
   wire ok_psusp = (cmd == fpss_pkg::CMD_READ_ARRAY) || (cmd == fpss_pkg::CMD_READ_STATUS)
      || (cmd == fpss_pkg::CMD_RESUME);
   wire ok_esusp = ok_psusp || is_prog || (cmd == fpss_pkg::CMD_SUSPEND);
   wire bad_cmd = wr && (st_r == ST_IDLE) && (p_susp ? !ok_psusp : (e_susp && !ok_esusp));

   // ---------------------------------------------------------------
   // Sequencer
   // ---------------------------------------------------------------
   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         st_r <= ST_IDLE;
         er_r <= EN_NONE;
         pg_r <= EN_NONE;
         sr_r <= fpss_pkg::SR_RESET;
         rd_status_r <= 1'b0;
         pcnt_r <= '0;
         ecnt_r <= '0;
         slat_r <= '0;
         paddr_r <= '0;
         eaddr_r <= '0;
      end else begin
         // Program and erase countdown and completion
         if (prog_run && pcnt_r != '0) pcnt_r <= pcnt_r - 1'b1;
         if (er_r == EN_RUN && pg_r == EN_NONE && ecnt_r != '0) ecnt_r <= ecnt_r - 1'b1;
         if (prog_done) begin
            pg_r <= EN_NONE;
            sr_r[fpss_pkg::SR_READY] <= 1'b1;
            // Error bits stay set until a clear status command
            sr_r[fpss_pkg::SR_PROG_ERR] <= sr_r[fpss_pkg::SR_PROG_ERR] | fault_any;
            sr_r[fpss_pkg::SR_VPP_LOW] <= sr_r[fpss_pkg::SR_VPP_LOW] | VPP_LOW_IN;
            sr_r[fpss_pkg::SR_LOCK] <= sr_r[fpss_pkg::SR_LOCK] | LOCKED_IN;
            // Nested program done: erase stays suspended, ready stays set
            if (er_r != EN_NONE) sr_r[fpss_pkg::SR_READY] <= 1'b1;
         end
         if (erase_done) begin
            er_r <= EN_NONE;
            sr_r[fpss_pkg::SR_READY] <= 1'b1;
         end
         // Suspend latency
         if (pg_r == EN_SUSPING || er_r == EN_SUSPING) begin
            if (slat_r != '0) slat_r <= slat_r - 1'b1;
            else if (pg_r == EN_SUSPING) begin
               pg_r <= EN_SUSP;
               sr_r[fpss_pkg::SR_READY] <= 1'b1;
               sr_r[fpss_pkg::SR_PROG_SUSP] <= 1'b1;
            end else begin
               er_r <= EN_SUSP;
               sr_r[fpss_pkg::SR_READY] <= 1'b1;
               sr_r[fpss_pkg::SR_ERASE_SUSP] <= 1'b1;
            end
         end
         if (bad_cmd) begin
            sr_r[fpss_pkg::SR_ERASE_ERR] <= 1'b1;
            sr_r[fpss_pkg::SR_PROG_ERR] <= 1'b1;
            rd_status_r <= 1'b1;
         end else if (wr) begin
            unique case (st_r)
               ST_PSETUP: begin
                  // Second write: address and data, start algorithm
                  st_r <= ST_IDLE;
                  pg_r <= EN_RUN;
                  paddr_r <= BUS.addr;
                  pcnt_r <= CNT_W_L'(PROG_CYCLES);
                  sr_r[fpss_pkg::SR_READY] <= 1'b0;
                  rd_status_r <= 1'b1;
               end
               ST_ESETUP: begin
                  st_r <= ST_IDLE;
                  rd_status_r <= 1'b1;
                  if (cmd == fpss_pkg::CMD_ERASE_CONFIRM) begin
                     er_r <= EN_RUN;
                     eaddr_r <= BUS.addr;
                     ecnt_r <= CNT_W_L'(ERASE_CYCLES);
                     sr_r[fpss_pkg::SR_READY] <= 1'b0;
                  end else begin
                     sr_r[fpss_pkg::SR_ERASE_ERR] <= 1'b1;
                     sr_r[fpss_pkg::SR_PROG_ERR] <= 1'b1;
                  end
               end
               default: begin
                  // Only read array ends status mode; clear status and the setups keep it, others select it
                  if (is_prog && pg_r == EN_NONE && er_r != EN_RUN
                        && er_r != EN_SUSPING) begin
                     st_r <= ST_PSETUP;
                  end else if (cmd == fpss_pkg::CMD_ERASE_SETUP && er_r == EN_NONE
                        && pg_r == EN_NONE) begin
                     st_r <= ST_ESETUP;
                  end else if (cmd == fpss_pkg::CMD_SUSPEND) begin
                     if (prog_run) begin
                        pg_r <= EN_SUSPING;
                        slat_r <= CNT_W_L'(SUSP_CYCLES);
                     end else if (er_r == EN_RUN && pg_r == EN_NONE) begin
                        er_r <= EN_SUSPING;
                        slat_r <= CNT_W_L'(SUSP_CYCLES);
                     end
                     rd_status_r <= 1'b1;
                  end else if (cmd == fpss_pkg::CMD_RESUME && p_susp) begin
                     pg_r <= EN_RUN;
                     sr_r[fpss_pkg::SR_READY] <= 1'b0;
                     sr_r[fpss_pkg::SR_PROG_SUSP] <= 1'b0;
                     rd_status_r <= 1'b1;
                  end else if (cmd == fpss_pkg::CMD_RESUME && e_susp) begin
                     er_r <= EN_RUN;
                     sr_r[fpss_pkg::SR_READY] <= 1'b0;
                     sr_r[fpss_pkg::SR_ERASE_SUSP] <= 1'b0;
                     rd_status_r <= 1'b1;
                  end else if (cmd == fpss_pkg::CMD_CLEAR_STATUS) begin
                     // A flag set in this same cycle wins over the clear
                     sr_r[fpss_pkg::SR_ERASE_ERR] <= 1'b0;
                     sr_r[fpss_pkg::SR_PROG_ERR] <= prog_done && fault_any;
                     sr_r[fpss_pkg::SR_VPP_LOW] <= prog_done && VPP_LOW_IN;
                     sr_r[fpss_pkg::SR_PROG_SUSP] <= psusp_set;
                     sr_r[fpss_pkg::SR_LOCK] <= prog_done && LOCKED_IN;
                  end else if (cmd == fpss_pkg::CMD_READ_ARRAY) begin
                     rd_status_r <= 1'b0;
                  end else begin
                     rd_status_r <= 1'b1;
                  end
               end
            endcase
         end
      end
   end

   // ---------------------------------------------------------------
   // Read path: status or array, one cycle later
   // ---------------------------------------------------------------
   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         rdata_r <= '0;
         rvalid_r <= 1'b0;
      end else begin
         rvalid_r <= BUS.rd && !BUS.ce_n;
         rdata_r <= (rd_status_r || pg_r == EN_RUN) ? DW'(sr_r) : ARRAY_DATA_IN;
      end
   end

   // Outputs
   assign ARRAY_ADDR_OUT = BUS.addr;
   assign BUS.rdata = rdata_r;
   assign BUS.rvalid = rvalid_r;
   assign STANDBY_OUT = BUS.ce_n && e_susp;
   assign BUSY_OUT = !sr_r[fpss_pkg::SR_READY];
   wire unused_ok = same_blk ^ (|paddr_r) ^ erase_done;
endmodule

// ---- logic/fpss_host.sv ----
`timescale 1ns/1ps
// Host end: turns user orders into bus cycles
module fpss_host #(
   parameter int AW = 16,
   parameter int DW = 16
) (
   // Clock and reset
   input wire logic CLK_IN,
   input wire logic RST_IN,
   // Bus to flash
   fpss_if.host BUS,
   // User side
   input wire logic WR_IN,
   input wire logic RD_IN,
   input wire logic [AW-1:0] ADDR_IN,
   input wire logic [DW-1:0] DATA_IN,
   input wire logic SELECT_IN,
   output logic [DW-1:0] DATA_OUT,
   output logic VALID_OUT,
   output logic ERROR_OUT
);
   // ---------------------------------------------------------------
   // Bus drive, registered
   // ---------------------------------------------------------------
   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         BUS.ce_n <= 1'b1;
         BUS.we <= 1'b0;
         BUS.rd <= 1'b0;
         BUS.addr <= '0;
         BUS.wdata <= '0;
         DATA_OUT <= '0;
         VALID_OUT <= 1'b0;
         ERROR_OUT <= 1'b0;
      end else begin
         BUS.ce_n <= !SELECT_IN;
         BUS.we <= WR_IN;
         BUS.rd <= RD_IN && !WR_IN;
         BUS.addr <= ADDR_IN;
         BUS.wdata <= DATA_IN;
         VALID_OUT <= BUS.rvalid;
         if (BUS.rvalid) begin
            DATA_OUT <= BUS.rdata;
            // Ready with program error flags a failure to inspect
            ERROR_OUT <= BUS.rdata[fpss_pkg::SR_READY] && BUS.rdata[fpss_pkg::SR_PROG_ERR];
         end
      end
   end
endmodule

// ---- tb/fpss_sva.sv ----
`timescale 1ns/1ps
// -----------------------------------------
// Bus and status checks on the shared bus
// -----------------------------------------
module fpss_sva #(parameter int AW = 16, parameter int DW = 16) (
   // Clock and reset
   input wire logic CLK_IN,
   input wire logic RST_IN,
   // Bus signals
   input wire logic ce_n,
   input wire logic we,
   input wire logic rd,
   input wire logic [AW-1:0] addr,
   input wire logic [DW-1:0] wdata,
   input wire logic [DW-1:0] rdata,
   input wire logic rvalid
);
   default clocking @(posedge CLK_IN); endclocking
   default disable iff (RST_IN);
   // Selected strobes and command bytes
   wire sel_rd = rd && !ce_n;
   wire sel_wr = we && !ce_n;
   wire [7:0] cmd = wdata[7:0];
   a_rvalid_after_rd: assert property (sel_rd |=> rvalid)
      else $error("read without answer");
   a_rvalid_cause: assert property (rvalid |-> $past(sel_rd))
      else $error("answer without read");
   a_strobe_excl: assert property (!(we && rd))
      else $error("write and read strobes together");
   a_prog_busy: assert property ((sel_wr && (cmd == 8'h40 || cmd == 8'h10)) ##1 sel_wr
      ##1 sel_rd |=> !rdata[7]) else $error("program did not show busy");
   a_susp_ready: assert property ((sel_wr && cmd == 8'hB0) ##1 !we [*3] ##1 sel_rd
      |=> rdata[7] && (rdata[6] || rdata[2])) else $error("suspend not shown");
   a_resume_busy: assert property ((sel_wr && cmd == 8'hD0) ##1 sel_rd
      |=> !rdata[7] && !rdata[2]) else $error("resume did not restart");
   a_clear_status: assert property ((sel_wr && cmd == 8'h50) ##1 (sel_wr && cmd == 8'h70)
      ##1 sel_rd |=> rdata[5:1] == 5'h0) else $error("status not cleared");
   a_bad_in_susp: assert property ((sel_wr && cmd == 8'hB0) ##1 !we [*3]
      ##1 (sel_wr && cmd == 8'h20) ##1 (sel_wr && cmd == 8'h70) ##1 sel_rd
      |=> rdata[5:4] == 2'h3) else $error("bad command not flagged");
   c_suspend: cover property (sel_wr && cmd == 8'hB0);
   c_nested: cover property (rvalid && rdata[6] && rdata[2]);
   c_bad_seq: cover property (rvalid && rdata[5:4] == 2'h3);
endmodule

// ---- tb/flash_program_suspend_sequencer_bench.sv ----
`timescale 1ns/1ps
module flash_program_suspend_sequencer_bench;
   // -----------------------------------------
   // Stimulus, design and checker
   // -----------------------------------------
   localparam logic [15:0] ARR = 16'hA5C3;
   logic clk = 1'b0, rst = 1'b1, wr_en = 1'b0, rd_en = 1'b0, sel = 1'b1;
   logic fail = 1'b0, vlow = 1'b0, lock = 1'b0;
   logic [15:0] addr = 16'h0000, wdata = 16'h0000, rdat;
   int miscompares = 0, total_checks = 0;
   wire [15:0] host_data;
   wire host_valid, host_err, standby, busy;
   wire [15:0] arr_addr;
   always #5 clk = ~clk;
   fpss_if #(.AW(16), .DW(16)) bus_if ();
   fpss_device #(.PROG_CYCLES(20), .ERASE_CYCLES(50), .SUSP_CYCLES(2)) u_fpss_device (
      .CLK_IN(clk), .RST_IN(rst), .BUS(bus_if), .ARRAY_DATA_IN(ARR), .PROG_FAIL_IN(fail),
      .VPP_LOW_IN(vlow), .LOCKED_IN(lock), .ARRAY_ADDR_OUT(arr_addr), .STANDBY_OUT(standby),
      .BUSY_OUT(busy));
   fpss_host u_fpss_host (.CLK_IN(clk), .RST_IN(rst), .BUS(bus_if), .WR_IN(wr_en),
      .RD_IN(rd_en), .ADDR_IN(addr), .DATA_IN(wdata), .SELECT_IN(sel),
      .DATA_OUT(host_data), .VALID_OUT(host_valid), .ERROR_OUT(host_err));
   fpss_sva u_fpss_sva (.CLK_IN(clk), .RST_IN(rst), .ce_n(bus_if.ce_n), .we(bus_if.we),
      .rd(bus_if.rd), .addr(bus_if.addr), .wdata(bus_if.wdata), .rdata(bus_if.rdata),
      .rvalid(bus_if.rvalid));
   // -----------------------------------------
   // Shared tasks
   // -----------------------------------------
   task test_done;
      $display("checks %0d miscompares %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task chk(input logic [15:0] got, input logic [15:0] exp, input logic [15:0] mask);
      total_checks++;
      if ((got & mask) !== exp) begin
         miscompares++;
         $display("[ERR] %0t got %h exp %h", $time, got & mask, exp);
      end
   endtask
   // Write strobe is held so writes may run back to back
   task wr(input logic [15:0] d, input logic [15:0] a);
      @(posedge clk);
      wr_en <= 1'b1;
      rd_en <= 1'b0;
      wdata <= d;
      addr <= a;
   endtask
   task idle(input int n);
      repeat (n) begin
         @(posedge clk);
         wr_en <= 1'b0;
         rd_en <= 1'b0;
      end
   endtask
   task rd(input logic [15:0] a);
      int i;
      @(posedge clk);
      wr_en <= 1'b0;
      rd_en <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd_en <= 1'b0;
      for (i = 0; i < 8; i++) begin
         @(negedge clk);
         if (host_valid === 1'b1) break;
      end
      rdat = host_data;
      if (i == 8) begin
         miscompares++;
         test_done();
      end
   endtask
   // Status reads until the ready bit comes back
   task poll;
      int n;
      for (n = 0; n < 60; n++) begin
         rd(16'h0000);
         if (rdat[7] === 1'b1) break;
      end
      if (n == 60) begin
         miscompares++;
         test_done();
      end
   endtask
   // -----------------------------------------
   // Scenarios
   // -----------------------------------------
   task s_program;
      for (int k = 0; k < 2; k++) begin
         wr(k ? 16'h0010 : 16'h0040, 16'h2000);
         wr(16'h1234, 16'h2000);
         rd(16'h2000);
         chk(rdat, 16'h0000, 16'h0080);
         chk({15'h0, busy}, 16'h0001, 16'h0001);
         poll();
         chk(rdat, 16'h0080, 16'h00FF);
         chk({15'h0, host_err}, 16'h0000, 16'h0001);
         rd(16'h0000);
         chk(rdat, 16'h0080, 16'h00FF);
      end
   endtask
   // Each fault mix, then clear before the next command
   task s_fault;
      for (int k = 1; k < 8; k++) begin
         @(posedge clk);
         {lock, vlow, fail} <= k[2:0];
         wr(16'h0040, 16'h2100);
         wr(16'h1234, 16'h2100);
         poll();
         chk(rdat, 16'h0090 | (k[1] ? 16'h0008 : 16'h0) | (k[2] ? 16'h0002 : 16'h0),
            16'h00FE);
         chk({15'h0, host_err}, 16'h0001, 16'h0001);
         @(posedge clk);
         {lock, vlow, fail} <= 3'h0;
         wr(16'h0050, 16'h0000);
         wr(16'h0070, 16'h0000);
         rd(16'h0000);
         chk(rdat, 16'h0080, 16'h00FF);
      end
   endtask
   task s_erase;
      wr(16'h0020, 16'h0000);
      wr(16'h00D0, 16'h0000);
      wr(16'h00B0, 16'h0000);
      idle(3);
      rd(16'h0000);
      chk(rdat, 16'h00C0, 16'h00C4);
      @(posedge clk);
      sel <= 1'b0;
      @(posedge clk);
      @(negedge clk);
      chk({15'h0, standby}, 16'h0001, 16'h0001);
      @(posedge clk);
      sel <= 1'b1;
      idle(2);
      wr(16'h00FF, 16'h3000);
      rd(16'h3000);
      chk(rdat, ARR, 16'hFFFF);
      chk(arr_addr, 16'h3000, 16'hFFFF);
      wr(16'h0040, 16'h3000);
      wr(16'h1234, 16'h3000);
      rd(16'h3000);
      chk(rdat, 16'h0040, 16'h00C4);
      wr(16'h00B0, 16'h3000);
      idle(3);
      rd(16'h0000);
      chk(rdat, 16'h00C4, 16'h00C4);
      wr(16'h0070, 16'h0000);
      rd(16'h0000);
      chk(rdat, 16'h00C4, 16'h00FC);
      wr(16'h00FF, 16'h3100);
      rd(16'h3100);
      chk(rdat, ARR, 16'hFFFF);
      wr(16'h00D0, 16'h0000);
      rd(16'h0000);
      chk(rdat, 16'h0040, 16'h00C4);
      poll();
      chk(rdat, 16'h00C0, 16'h00FF);
      wr(16'h00D0, 16'h0000);
      rd(16'h0000);
      chk(rdat, 16'h0000, 16'h00C4);
      poll();
      chk(rdat, 16'h0080, 16'h00FF);
   endtask
   task s_bad;
      wr(16'h0020, 16'h0000);
      wr(16'h00D0, 16'h0000);
      wr(16'h00B0, 16'h0000);
      idle(3);
      wr(16'h0020, 16'h0000);
      wr(16'h0070, 16'h0000);
      rd(16'h0000);
      chk(rdat, 16'h00F0, 16'h00F0);
      wr(16'h00D0, 16'h0000);
      rd(16'h0000);
      poll();
      chk(rdat, 16'h00B0, 16'h00F4);
      wr(16'h0050, 16'h0000);
      wr(16'h0070, 16'h0000);
      rd(16'h0000);
      chk(rdat, 16'h0080, 16'h00FF);
   endtask
   // Main sequence
   initial begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      s_program();
      s_fault();
      s_erase();
      s_bad();
      test_done();
   end
endmodule
